// ### adcsp_sync.sv
// Purpose: shared constants of the differential serial port, plus a two-stage synchroniser
// Assumes: everything runs on mclk; pin inputs arrive asynchronously
// Notes:   the first stage of the synchroniser is read by the second stage only
`timescale 1ns/100ps
`default_nettype none

package adcsp_pkg;
    localparam int          WORD_W     = 8;        // control word length
    localparam int          RES_W      = 16;       // conversion result length
    localparam int          FRAME_W    = 24;       // result plus configuration byte
    localparam int          SYNC_W     = 4;        // strap, select, clock, data
    localparam int          HDR_HI     = 7;        // header field, top bit
    localparam int          HDR_LO     = 6;        // header field, low bit
    localparam int          CH_HI      = 5;        // channel field, top bit
    localparam int          CH_LO      = 3;        // channel field, low bit
    localparam int          RNG_HI     = 2;        // range field, top bit
    localparam int          RNG_SPAN   = 2;        // range bit: 2.5x versus 1.25x span
    localparam int          RNG_BIP    = 1;        // range bit: bipolar versus unipolar
    localparam int          RNG_FULL   = 0;        // range bit: cleared divides by 1.024
    localparam logic [1:0]  HDR_VAL    = 2'h2;     // fixed header pattern 10
    localparam logic [1:0]  CFG_PAD    = 2'h0;     // pad bits ahead of channel in frame
    localparam logic [2:0]  CNT_LAST   = 3'h7;     // last bit index of a control word
    localparam logic [2:0]  CNT_ONE    = 3'h1;     // bit counter step
    localparam logic [7:0]  WORD_ZERO  = 8'h00;    // all-zero word: run the sequence
endpackage

// two flip-flops per bit; the output is the only thing logic may read
module adcsp_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire  logic         mclk,
    input  wire  logic         reset_n,
    // asynchronous in, synchronous out
    input  wire  logic [W-1:0] async_i,
    output var   logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;   // first stage, read only by the second

    // plain double register, reset to zero
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule

`default_nettype wire

// ### adcsp_port.sv
// Purpose: differential double-data-rate serial port of a multiplexed converter
// Assumes: mclk at 100 MHz oversamples the shift clock (80 ns period in the bench)
// Notes:   both clock edges move data; the strap is caught once after reset
// Notes on behaviour
// - capture input bit on both clock edges
// - launch output bit on both clock edges
// - stream latest result with its channel configuration
// - forward shift clock aligned with output data
// - port works only while select is low
// - select high: outputs go high impedance
// - select gates the incoming shift clock
// - terminations on only while select low
// - single-ended input off in differential mode, ignored
// - range is a three-bit code, eight values
// - range bits: span, polarity, 1.024 divide
// - bipolar twos complement, unipolar straight binary
// - mode strap high selects differential mode
// - all-zero word continues the programmed sequence
`timescale 1ns/100ps
`default_nettype none

module adcsp_port
    import adcsp_pkg::*;
(
    // clock and reset
    input  wire  logic              mclk,
    input  wire  logic              reset_n,
    // pins from the host
    input  wire  logic              cs_n_pin,
    input  wire  logic              diff_shift_clock_in,
    input  wire  logic              diff_serial_in,
    input  wire  logic              io_mode_strap,
    // pins to the host, enables low while driving
    output logic                    diff_serial_out,
    output logic                    diff_serial_out_oe_n,
    output logic                    diff_forwarded_clock_out,
    output logic                    diff_forwarded_clock_oe_n,
    output logic                    term_enable,
    output logic                    single_ended_in_enable,
    // converter core side
    input  wire  logic              result_valid,
    input  wire  logic [RES_W-1:0]  result_raw,
    input  wire  logic [2:0]        result_channel,
    input  wire  logic [2:0]        result_range,
    // decoded control towards the multiplexer and sequencer
    output logic [WORD_W-1:0]       ctrl_word,
    output logic                    ctrl_valid,
    output logic                    seq_next,
    output logic [2:0]              ctrl_channel,
    output logic [2:0]              ctrl_range,
    output logic                    span_large,
    output logic                    span_bipolar,
    output logic                    span_full
);
    // whole module state
    typedef struct packed {
        logic               mode_done;   // strap has been caught
        logic [1:0]         arm;         // ones shift in after reset: strap sync settled
        logic               diff_mode;   // differential mode selected
        logic               sck_prev;    // last seen shift clock level
        logic               cs_prev;     // last seen select level
        logic [WORD_W-1:0]  rx_sh;       // incoming word shifter
        logic [2:0]         rx_cnt;      // bits of current word
        logic [FRAME_W-1:0] tx_sh;       // outgoing frame shifter
        logic               sdo;         // output data bit
        logic               sdo_oe_n;    // output data enable
        logic               sck_out;     // forwarded clock
        logic               sck_oe_n;    // forwarded clock enable
        logic               term;        // termination switch
        logic               se_en;       // single-ended input enable
        logic [WORD_W-1:0]  word;        // last decoded control word
        logic               wvalid;      // pulse: new control word
        logic               seq;         // pulse: all-zero word seen
        logic               span_l;      // 2.5x span selected
        logic               bip;         // bipolar selected
        logic               full;        // undivided span selected
        logic [RES_W-1:0]   res_word;    // formatted latest result
        logic [WORD_W-1:0]  res_cfg;     // its configuration byte
    } adcsp_state_t;

    adcsp_state_t st_q;     // registered state
    adcsp_state_t st_d;     // next state
    logic [SYNC_W-1:0] sync_s;   // synchronised pins
    logic strap_s;          // synchronised strap
    logic cs_n_s;           // synchronised select
    logic sck_s;            // synchronised shift clock
    logic sdi_s;            // synchronised data in
    logic active;           // port enabled this cycle
    logic edge_seen;        // either shift clock edge, gated
    logic [WORD_W-1:0] rx_next;  // word with the new bit in
    logic [FRAME_W-1:0] frame;   // frame ready to load

    // all pins cross into mclk together so data and clock stay coherent
    adcsp_sync #(.W(SYNC_W)) u_sync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .async_i ({io_mode_strap, cs_n_pin, diff_shift_clock_in, diff_serial_in}),
        .sync_o  (sync_s)
    );
    assign {strap_s, cs_n_s, sck_s, sdi_s} = sync_s;

    // select low in differential mode opens the port
    assign active    = st_q.diff_mode && !cs_n_s;
    // edges while select is high never reach the shifters
    assign edge_seen = active && !st_q.cs_prev && (sck_s != st_q.sck_prev);
    assign rx_next   = {st_q.rx_sh[WORD_W-2:0], sdi_s};
    assign frame     = {st_q.res_word, st_q.res_cfg};

    // next-state logic
    always_comb begin
        st_d          = st_q;
        st_d.wvalid   = 1'b0;
        st_d.seq      = 1'b0;
        st_d.sck_prev = sck_s;
        st_d.cs_prev  = cs_n_s;
        // strap read once, never again; wait until the synchroniser shows the pin
        // and not its own reset value, or the port would never open
        st_d.arm = {st_q.arm[0], 1'b1};
        if (!st_q.mode_done && st_q.arm[1]) begin
            st_d.mode_done = 1'b1;
            st_d.diff_mode = strap_s;
        end
        // single-ended pin unused in differential mode
        st_d.se_en = st_q.mode_done && !st_q.diff_mode;
        // keep only the newest result; straight binary from the core
        if (result_valid) begin
            // flip msb for bipolar codes to get twos complement
            st_d.res_word = result_range[RNG_BIP]
                          ? {~result_raw[RES_W-1], result_raw[RES_W-2:0]}
                          : result_raw;
            st_d.res_cfg  = {CFG_PAD, result_channel, result_range};
        end
        if (!active) begin
            // port closed: release pins, terminations off
            st_d.sdo_oe_n = 1'b1;
            st_d.sck_oe_n = 1'b1;
            st_d.sck_out  = 1'b0;
            st_d.sdo      = 1'b0;
            st_d.term     = 1'b0;
            st_d.rx_cnt   = '0;
        end else begin
            st_d.sdo_oe_n = 1'b0;
            st_d.sck_oe_n = 1'b0;
            st_d.term     = 1'b1;
            // forwarded clock moves in the same cycle as the data
            st_d.sck_out  = sck_s;
            if (st_q.cs_prev) begin
                // frame start: first bit out before any clock edge
                st_d.sdo   = frame[FRAME_W-1];
                st_d.tx_sh = {frame[FRAME_W-2:0], 1'b0};
            end else if (edge_seen) begin
                // rising or falling alike
                st_d.rx_sh  = rx_next;
                st_d.rx_cnt = st_q.rx_cnt + CNT_ONE;
                st_d.sdo    = st_q.tx_sh[FRAME_W-1];
                st_d.tx_sh  = {st_q.tx_sh[FRAME_W-2:0], 1'b0};
                // msb first, word complete on eighth bit
                if (st_q.rx_cnt == CNT_LAST) begin
                    if (rx_next == WORD_ZERO) begin
                        st_d.seq = 1'b1;
                    end else if (rx_next[HDR_HI:HDR_LO] == HDR_VAL) begin
                        st_d.word   = rx_next;
                        st_d.wvalid = 1'b1;
                        st_d.span_l = rx_next[RNG_SPAN];
                        st_d.bip    = rx_next[RNG_BIP];
                        st_d.full   = rx_next[RNG_FULL];
                    end
                end
            end
        end
    end

    // single state register, constants only under reset
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_q          <= '0;
            st_q.sdo_oe_n <= 1'b1;
            st_q.sck_oe_n <= 1'b1;
            st_q.cs_prev  <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // every output straight from the state register
    assign diff_serial_out           = st_q.sdo;
    assign diff_serial_out_oe_n      = st_q.sdo_oe_n;
    assign diff_forwarded_clock_out  = st_q.sck_out;
    assign diff_forwarded_clock_oe_n = st_q.sck_oe_n;
    assign term_enable               = st_q.term;
    assign single_ended_in_enable    = st_q.se_en;
    assign ctrl_word                 = st_q.word;
    assign ctrl_valid                = st_q.wvalid;
    assign seq_next                  = st_q.seq;
    assign ctrl_channel              = st_q.word[CH_HI:CH_LO];
    assign ctrl_range                = st_q.word[RNG_HI:0];
    assign span_large                = st_q.span_l;
    assign span_bipolar              = st_q.bip;
    assign span_full                 = st_q.full;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    rx_capture_a: assert property (edge_seen |=> st_q.rx_sh[0] == $past(sdi_s))
        else $error("input bit not captured on clock edge");
    tx_launch_a: assert property (edge_seen |=> st_q.sdo == $past(st_q.tx_sh[FRAME_W-1]))
        else $error("output bit not launched on clock edge");
    frame_load_a: assert property (active && st_q.cs_prev
            |=> st_q.sdo == $past(st_q.res_word[RES_W-1]) && !st_q.sdo_oe_n)
        else $error("frame did not start with latest result");
    fwd_clock_a: assert property (active ##1 active |-> st_q.sck_out == $past(sck_s))
        else $error("forwarded clock not aligned to data");
    hiz_out_a: assert property (cs_n_s |=> st_q.sdo_oe_n && st_q.sck_oe_n)
        else $error("outputs driven while deselected");
    clock_gate_a: assert property (cs_n_s ##1 cs_n_s |=> $stable(st_q.rx_sh))
        else $error("clock edge acted while deselected");
    term_follow_a: assert property (##1 st_q.term == $past(active))
        else $error("termination not following select");
    se_pin_off_a: assert property (st_q.mode_done && st_q.diff_mode |=> !st_q.se_en)
        else $error("single-ended input enabled in differential mode");
    strap_catch_a: assert property (st_q.arm[1] && !st_q.mode_done
            |=> st_q.diff_mode == $past(strap_s))
        else $error("mode strap not caught after reset");
    word_header_a: assert property (st_q.wvalid |-> st_q.word[HDR_HI:HDR_LO] == HDR_VAL
            && !st_q.seq)
        else $error("control word accepted without header");
    twos_comp_a: assert property (result_valid && result_range[RNG_BIP]
            |=> st_q.res_word[RES_W-1] != $past(result_raw[RES_W-1]))
        else $error("bipolar result not in twos complement");
endmodule

`default_nettype wire

// ### adcsp_host.sv
// Purpose: host-side model that drives the differential serial port pins
// Assumes: driven on falling mclk edges; link half period is 4 mclk (80 ns period)
// Notes:   returned data is taken on both forwarded clock edges
`timescale 1ns/100ps
`default_nettype none

module adcsp_host (
    // bench clock
    input  wire  logic        mclk,
    // pins from the device
    input  wire  logic        diff_serial_out,
    input  wire  logic        diff_serial_out_oe_n,
    input  wire  logic        diff_forwarded_clock_out,
    // pins to the device
    output var   logic        cs_n_pin,
    output var   logic        diff_shift_clock_in,
    output var   logic        diff_serial_in,
    // captured frame
    output var   logic [23:0] frame_q,
    output var   logic        frame_done
);
    logic       busy;     // data line owned by a transfer
    logic       sck_prev; // last forwarded clock level seen
    logic [5:0] cnt;      // bits taken in this frame

    // idle: deselected, clock low
    initial begin
        cs_n_pin = 1'b1;
        diff_shift_clock_in = 1'b0;
        diff_serial_in = 1'b0;
        busy = 1'b0;
        cnt = 6'h00;
        frame_done = 1'b0;
    end

    // released data line toggles so a stale level can never pass for data
    always @(negedge mclk) if (!busy) diff_serial_in <= ~diff_serial_in;

    // take data on every forwarded clock change, first bit as the port opens
    always @(posedge mclk) begin
        frame_done <= 1'b0;
        sck_prev <= diff_forwarded_clock_out;
        if (!diff_serial_out_oe_n && cnt < 6'h18 &&
            (cnt == 6'h00 || diff_forwarded_clock_out != sck_prev)) begin
            frame_q <= {frame_q[22:0], diff_serial_out};
            cnt <= cnt + 6'h01;
        end
        if (diff_serial_out_oe_n && cnt != 6'h00) begin
            frame_done <= (cnt == 6'h18); // partial frames are not reported
            cnt <= 6'h00;
        end
    end

    // one framed transfer of n bits, msb first; n even so the clock ends low
    task automatic xfer(input logic [23:0] bits, input int n);
        busy = 1'b1;
        @(negedge mclk);
        cs_n_pin = 1'b0;
        repeat (4) @(negedge mclk);
        for (int i = 0; i < n; i++) begin
            diff_serial_in = bits[23-i];
            repeat (2) @(negedge mclk);
            diff_shift_clock_in = ~diff_shift_clock_in;
            repeat (2) @(negedge mclk);
        end
        repeat (4) @(negedge mclk);
        cs_n_pin = 1'b1;
        repeat (4) @(negedge mclk);
        busy = 1'b0;
    endtask

    // clock pulse while deselected, which the port must ignore
    task automatic stray_clock();
        repeat (2) begin
            repeat (4) @(negedge mclk);
            diff_shift_clock_in = ~diff_shift_clock_in;
        end
    endtask
endmodule

`default_nettype wire

// ### tb_adc_lvds_ddr_serial_port.sv
// Purpose: self-checking bench for the differential serial port
// Assumes: 100 MHz mclk, strap high for differential mode until the final strap-low test
// Notes:   drivers queue expectations, a monitor pops them as results appear
`timescale 1ns/100ps
`default_nettype none

module tb_adc_lvds_ddr_serial_port;
    import adcsp_pkg::*;
    logic        mclk, reset_n, rv, cs_n, sck, single_ended_serial_in, sdo, oe_d, fwd, oe_c, term, se_en;
    logic        cv, seq, sl, sb, sf, fdone, strap;
    logic [15:0] raw;
    logic [2:0]  rch, rrng, cch, crng;
    logic [7:0]  cword;
    logic [23:0] fq;
    logic [23:0] qf[$];      // expected frames
    logic [8:0]  qc[$];      // expected words, msb marks a sequence step
    int          err_count, n_tests, cycles;

    adcsp_port u_dut (.mclk(mclk), .reset_n(reset_n), .cs_n_pin(cs_n),
        .diff_shift_clock_in(sck), .diff_serial_in(single_ended_serial_in), .io_mode_strap(strap),
        .diff_serial_out(sdo), .diff_serial_out_oe_n(oe_d), .diff_forwarded_clock_out(fwd),
        .diff_forwarded_clock_oe_n(oe_c), .term_enable(term), .single_ended_in_enable(se_en),
        .result_valid(rv), .result_raw(raw), .result_channel(rch), .result_range(rrng),
        .ctrl_word(cword), .ctrl_valid(cv), .seq_next(seq), .ctrl_channel(cch),
        .ctrl_range(crng), .span_large(sl), .span_bipolar(sb), .span_full(sf));
    adcsp_host u_host (.mclk(mclk), .diff_serial_out(sdo), .diff_serial_out_oe_n(oe_d),
        .diff_forwarded_clock_out(fwd), .cs_n_pin(cs_n), .diff_shift_clock_in(sck),
        .diff_serial_in(single_ended_serial_in), .frame_q(fq), .frame_done(fdone));

    // free-running bench clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic tally(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask
    task automatic cmp_frame(input logic [23:0] got);
        tally(qf.size() > 0 && got === qf.pop_front(), "returned frame differs");
    endtask
    task automatic cmp_ctrl(input logic [17:0] got);
        logic [8:0] e;
        e = (qc.size() > 0) ? qc.pop_front() : 9'hxxx;
        tally(got === (e[8] ? {1'b1, 17'h0} : {1'b0, e[7:0], e[5:3], e[2:0], e[2:0]}),
              "decoded control differs");
    endtask
    task automatic cmp_pin(input logic [3:0] got, input logic [3:0] exp);
        tally(got === exp, "pin levels differ");
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // a fresh result, then one 24-bit frame carrying w1, w2 and a dropped word
    task automatic run(input logic [7:0] w1, input logic [7:0] w2);
        @(negedge mclk);
        raw = 16'($urandom);
        rch = 3'($urandom);
        rrng = w1[2:0];
        rv = 1'b1;
        @(negedge mclk);
        rv = 1'b0;
        qf.push_back({raw ^ {rrng[RNG_BIP], 15'h0}, CFG_PAD, rch, rrng});
        if (w1 == WORD_ZERO || w1[7:6] == HDR_VAL) qc.push_back({w1 == WORD_ZERO, w1});
        if (w2 == WORD_ZERO || w2[7:6] == HDR_VAL) qc.push_back({w2 == WORD_ZERO, w2});
        u_host.xfer({w1, w2, 8'hff}, 24);
    endtask

    // monitor: pin levels every cycle while out of reset with the strap high, results as they appear
    always @(posedge mclk) begin
        cycles++;
        // pin levels fixed only in differential mode; the strap-low test checks its own
        if (reset_n && strap)
            cmp_pin({term, se_en, oe_c, oe_d & fwd},
                    {~oe_d, 1'b0, oe_d, 1'b0});
        if (fdone) cmp_frame(fq);
        if (cv) cmp_ctrl({1'b0, cword, cch, crng, sl, sb, sf});
        if (seq) cmp_ctrl({1'b1, 17'h0});
        if (cycles == 20000) begin
            err_count++;
            $display("Error at %0t: run hung", $time);
            stop_test();
        end
    end

    // main sequence
    initial begin
        void'($urandom(32'he237));
        {reset_n, rv, raw, rch, rrng, err_count, n_tests, cycles} = '0;
        strap = 1'b1;
        repeat (3) @(negedge mclk);
        reset_n = 1'b1;
        repeat (6) @(negedge mclk);
        cmp_pin({term, se_en, oe_c, oe_d}, 4'h3);
        $display("test idle done");
        for (int s = 0; s < 8; s++) run({HDR_VAL, 3'($urandom), 3'(s)}, 8'hff);
        $display("test range codes done");
        run({HDR_VAL, 3'h5, 3'h3}, {HDR_VAL, 3'h2, 3'h6});
        $display("test back to back done");
        run(WORD_ZERO, 8'h7f);
        $display("test zero and bad header done");
        u_host.stray_clock();
        repeat (4) @(negedge mclk);
        cmp_pin({fwd, oe_d, oe_c, term}, 4'h6);
        u_host.xfer(24'hb5a5a5, 4);
        run({HDR_VAL, 3'h7, 3'h1}, 8'hc0);
        $display("test gated clock and abort done");
        // mid-run reset with the strap low: port stays shut, single-ended input on
        repeat (10) @(negedge mclk);
        reset_n = 1'b0;
        strap = 1'b0;
        repeat (3) @(negedge mclk);
        reset_n = 1'b1;
        repeat (6) @(negedge mclk);
        fork
            u_host.xfer({HDR_VAL, 3'h4, 3'h5, 16'h0}, 8);
            repeat (40) begin
                @(negedge mclk);
                cmp_pin({term, se_en, oe_c, oe_d}, 4'h7);
            end
        join
        $display("test single-ended strap done");
        repeat (10) @(negedge mclk);
        tally(qf.size() == 0 && qc.size() == 0, "expected results never appeared");
        stop_test();
    end
endmodule

`default_nettype wire
